/* tbi_rx_pkg.sv */
// Constants for the ten-bit interface receive capture stage.
// Assumes one system clock to which all link pins are synchronous.
// How it works
// R1: Capture clk0 rise, then clk1 rise.
// R2: Default scheme uses both receive clocks.
// R3: Antiphase scheme uses both clk0 edges.
// R4: Partner keeps clocks exactly antiphase.
// R5: Inverted clk0 replaces clk1 locally.
// R6: Same-edge pair presented on clk0 rise.
// R7: Captured words resampled before passing onward.
// R8: Dual scheme duplicates capture for clk1.
// R9: First-clock sample always precedes second.
`default_nettype none

package tbi_rx_pkg;

   // ------------------------------------------------------------------
   // Widths and depths
   // ------------------------------------------------------------------
   localparam int unsigned CODE_W     = 10;
   localparam int unsigned FIFO_DEPTH = 8;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [CODE_W-1:0] CODE_RST = 10'h000;

endpackage : tbi_rx_pkg

`default_nettype wire

/* tbi_rx_fifo.sv */
// Synchronous FIFO of flip-flops with valid and ready on both sides.
// Assumes a single clock and an asynchronous active-low reset.
`default_nettype none

module tbi_rx_fifo #(
   parameter int unsigned WIDTH = 20,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
   assign out_valid_o = (count_q != '0);
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // ------------------------------------------------------------------
   // Pointers and fill level
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_q    <= '0;
         rd_q    <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule : tbi_rx_fifo

`default_nettype wire

/* tbi_receive_capture.sv */
// Receive capture stage of a ten-bit interface.
// Assumes receive clocks and code-group bus are synchronous to ref_clk_i
// and are sampled as ordinary levels.
`default_nettype none

module tbi_receive_capture #(
   parameter int unsigned CODE_W = tbi_rx_pkg::CODE_W,
   parameter int unsigned DEPTH  = tbi_rx_pkg::FIFO_DEPTH
) (
   input  wire logic              ref_clk_i,
   input  wire logic              reset_n_i,
   input  wire logic              single_clock_mode_i,
   input  wire logic              pma_rx_clk0_i,
   input  wire logic              pma_rx_clk1_i,
   input  wire logic [CODE_W-1:0] rx_code_group_i,
   input  wire logic              out_ready_i,
   output logic      [CODE_W-1:0] rising_sample_out_o,
   output logic      [CODE_W-1:0] falling_sample_out_o,
   output logic                   out_valid_o,
   output logic                   capture_ready_o,
   output logic                   overflow_o
);

   // ------------------------------------------------------------------
   // Edge detection on the receive clocks
   // ------------------------------------------------------------------
   logic              clk0_q;
   logic              clk1_q;
   logic              clk1_eff;
   logic              rise0;
   logic              rise1;

   // The second capture clock is clk1, or inverted clk0 when antiphase.
   assign clk1_eff = single_clock_mode_i ? ~pma_rx_clk0_i
                                         : pma_rx_clk1_i; // [R5] [R2] [R4]
   assign rise0    = pma_rx_clk0_i && !clk0_q;
   assign rise1    = clk1_eff && !clk1_q; // [R3] [R8]

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         clk0_q <= 1'b0;
         clk1_q <= 1'b0;
      end else begin
         clk0_q <= pma_rx_clk0_i;
         clk1_q <= clk1_eff;
      end
   end

   // ------------------------------------------------------------------
   // Input capture of the code-group bus
   // ------------------------------------------------------------------
   logic [CODE_W-1:0] first_q;
   logic [CODE_W-1:0] second_q;
   logic              have_first_q;
   logic              pair_pend_q;
   logic              cap_valid_q;
   logic [CODE_W-1:0] cap_first_q;
   logic [CODE_W-1:0] cap_second_q;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         first_q      <= tbi_rx_pkg::CODE_RST;
         second_q     <= tbi_rx_pkg::CODE_RST;
         have_first_q <= 1'b0;
         pair_pend_q  <= 1'b0;
         cap_valid_q  <= 1'b0;
         cap_first_q  <= tbi_rx_pkg::CODE_RST;
         cap_second_q <= tbi_rx_pkg::CODE_RST;
      end else begin
         cap_valid_q <= 1'b0;
         if (rise0) begin
            // A word always opens on a clk0 rising edge.
            first_q      <= rx_code_group_i; // [R1]
            have_first_q <= 1'b1;
            if (single_clock_mode_i && pair_pend_q) begin
               // Both samples leave together on the clk0 rise.
               cap_valid_q  <= 1'b1; // [R6]
               cap_first_q  <= first_q; // [R9]
               cap_second_q <= second_q;
               pair_pend_q  <= 1'b0;
            end
         end else if (rise1 && have_first_q) begin
            have_first_q <= 1'b0;
            if (single_clock_mode_i) begin
               second_q    <= rx_code_group_i; // [R3]
               pair_pend_q <= 1'b1;
            end else begin
               cap_valid_q  <= 1'b1; // [R1] [R8]
               cap_first_q  <= first_q; // [R9]
               cap_second_q <= rx_code_group_i;
               pair_pend_q  <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Resample stage ahead of the buffer
   // ------------------------------------------------------------------
   logic                  rs_valid_q;
   logic [2*CODE_W-1:0]   rs_data_q;
   logic                  fifo_in_ready;
   logic                  fifo_out_valid;
   logic [2*CODE_W-1:0]   fifo_out_data;
   logic                  fifo_pop;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rs_valid_q <= 1'b0;
         rs_data_q  <= '0;
      end else begin
         rs_valid_q <= cap_valid_q; // [R7]
         rs_data_q  <= {cap_first_q, cap_second_q}; // [R7] [R9]
      end
   end

   // Overflow is sticky until reset because the link cannot be stalled.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         overflow_o      <= 1'b0;
         capture_ready_o <= 1'b0;
      end else begin
         capture_ready_o <= fifo_in_ready;
         if (rs_valid_q && !fifo_in_ready) begin
            overflow_o <= 1'b1;
         end
      end
   end

   tbi_rx_fifo #(
      .WIDTH (2 * CODE_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (rs_valid_q),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (rs_data_q),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out_data)
   );

   // ------------------------------------------------------------------
   // Output register
   // ------------------------------------------------------------------
   assign fifo_pop = fifo_out_valid && (!out_valid_o || out_ready_i);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_valid_o          <= 1'b0;
         rising_sample_out_o  <= tbi_rx_pkg::CODE_RST;
         falling_sample_out_o <= tbi_rx_pkg::CODE_RST;
      end else if (!out_valid_o || out_ready_i) begin
         out_valid_o <= fifo_out_valid;
         if (fifo_out_valid) begin
            rising_sample_out_o  <= fifo_out_data[2*CODE_W-1:CODE_W]; // [R9]
            falling_sample_out_o <= fifo_out_data[CODE_W-1:0];
         end
      end
   end

endmodule : tbi_receive_capture

`default_nettype wire

/* tbi_rx_chk.sv */
// Assertions on the ports of the receive capture stage.
// Assumes binding to every instance of the capture stage.
`default_nettype none
module tbi_rx_chk #(
   parameter int unsigned CODE_W = 10,
   parameter int unsigned DEPTH  = 8
) (
   input wire logic              ref_clk_i,
   input wire logic              reset_n_i,
   input wire logic              single_clock_mode_i,
   input wire logic              pma_rx_clk0_i,
   input wire logic              pma_rx_clk1_i,
   input wire logic [CODE_W-1:0] rx_code_group_i,
   input wire logic              out_ready_i,
   input wire logic [CODE_W-1:0] rising_sample_out_o,
   input wire logic [CODE_W-1:0] falling_sample_out_o,
   input wire logic              out_valid_o,
   input wire logic              capture_ready_o,
   input wire logic              overflow_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   a_dual_pair:
      assert property (!single_clock_mode_i && !out_valid_o
         && $rose(pma_rx_clk0_i) ##1 $rose(pma_rx_clk1_i)
         && !$rose(pma_rx_clk0_i) ##0 out_ready_i[*4] |=> out_valid_o
         && rising_sample_out_o == $past(rx_code_group_i, 5)
         && falling_sample_out_o == $past(rx_code_group_i, 4))
      else $error("dual pair wrong");
   a_single_pair:
      assert property (single_clock_mode_i && !out_valid_o
         && $rose(pma_rx_clk0_i) ##1 $fell(pma_rx_clk0_i)
         ##2 $rose(pma_rx_clk0_i) ##0 out_ready_i[*4] |=> out_valid_o
         && rising_sample_out_o == $past(rx_code_group_i, 7)
         && falling_sample_out_o == $past(rx_code_group_i, 6))
      else $error("single pair wrong");
   a_hold_out:
      assert property (out_valid_o && !out_ready_i |=> out_valid_o
         && $stable(rising_sample_out_o) && $stable(falling_sample_out_o))
      else $error("pair moved while stalled");
   a_idle_quiet:
      assert property ((!out_valid_o && !pma_rx_clk0_i
         && (single_clock_mode_i || !pma_rx_clk1_i))[*6] |=> !out_valid_o)
      else $error("pair without edges");
   a_ovf_sticky:
      assert property (overflow_o |=> overflow_o)
      else $error("overflow cleared");
   a_full_valid:
      assert property ($past(reset_n_i) && !capture_ready_o |-> out_valid_o)
      else $error("full but nothing valid");
   a_room_idle:
      assert property ($past(reset_n_i) && !out_valid_o
         && !$past(out_valid_o) |-> capture_ready_o)
      else $error("no room while empty");
   a_ready_boot:
      assert property ($rose(reset_n_i) |=> capture_ready_o)
      else $error("not ready after reset");
endmodule : tbi_rx_chk
bind tbi_receive_capture tbi_rx_chk #(.CODE_W(CODE_W), .DEPTH(DEPTH))
   tbi_rx_chk_inst (.ref_clk_i, .reset_n_i, .single_clock_mode_i,
   .pma_rx_clk0_i, .pma_rx_clk1_i, .rx_code_group_i, .out_ready_i,
   .rising_sample_out_o, .falling_sample_out_o, .out_valid_o,
   .capture_ready_o, .overflow_o);
`default_nettype wire

/* tbi_serdes_model.sv */
// Serializer model driving receive clocks and code-group bus.
// Assumes send_i is raised for one cycle per pair of words.
`default_nettype none
module tbi_serdes_model (
   input  wire logic       ref_clk_i,
   input  wire logic       single_i,
   input  wire logic       send_i,
   input  wire logic [9:0] a_i,
   input  wire logic [9:0] b_i,
   output logic            clk0_o,
   output logic            clk1_o,
   output logic      [9:0] code_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] step_q = 2'h0;
   logic       clk0_q = 1'b0;
   logic       clk1_q = 1'b0;
   logic [9:0] code_q = 10'h2aa;
   assign clk0_o = clk0_q;
   assign clk1_o = single_i ? ~clk0_q : clk1_q;
   assign code_o = code_q;
   always @(negedge ref_clk_i) begin
      case (step_q)
         2'h0: if (send_i) begin
            clk0_q <= 1'b1;
            code_q <= a_i;
            step_q <= 2'h1;
         end
         2'h1: begin
            clk0_q <= 1'b0;
            clk1_q <= ~single_i;
            code_q <= b_i;
            step_q <= 2'h2;
         end
         default: begin
            clk1_q <= 1'b0;
            code_q <= ~b_i;
            step_q <= 2'h0;
         end
      endcase
   end
endmodule : tbi_serdes_model
`default_nettype wire

/* test_tbi_receive_capture.sv */
// Self-checking bench for the ten-bit receive capture stage.
// Assumes the serializer model and the bound checker.
`default_nettype none
module test_tbi_receive_capture;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_i = 1'b0, reset_n_i = 1'b0, single = 1'b0;
   logic        send = 1'b0, ready = 1'b1, c0, c1, valid, cap, ovf;
   logic [9:0]  a = 10'h000, b = 10'h000, code, rs, fs;
   logic [19:0] q[$];
   int          n_errors = 0, n_checks = 0;
   always #20 ref_clk_i = ~ref_clk_i;
   tbi_serdes_model tbi_serdes_model_inst (.ref_clk_i, .single_i(single),
      .send_i(send), .a_i(a), .b_i(b), .clk0_o(c0), .clk1_o(c1),
      .code_o(code));
   tbi_receive_capture tbi_receive_capture_inst (.ref_clk_i, .reset_n_i,
      .single_clock_mode_i(single), .pma_rx_clk0_i(c0), .pma_rx_clk1_i(c1),
      .rx_code_group_i(code), .out_ready_i(ready), .rising_sample_out_o(rs),
      .falling_sample_out_o(fs), .out_valid_o(valid),
      .capture_ready_o(cap), .overflow_o(ovf));
   always @(posedge ref_clk_i)
      if (valid === 1'b1 && ready === 1'b1)
         q.push_back({rs, fs});
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic send_pair(input logic [9:0] x, input logic [9:0] y);
      @(negedge ref_clk_i);
      send <= 1'b1;
      a <= x;
      b <= y;
      @(negedge ref_clk_i);
      send <= 1'b0;
      @(negedge ref_clk_i);
   endtask : send_pair
   task automatic pop(input logic [9:0] x, input logic [9:0] y);
      logic [19:0] w;
      w = 'x;
      for (int i = 0; i < 20 && q.size() == 0; i++)
         @(negedge ref_clk_i);
      if (q.size() > 0)
         w = q.pop_front();
      check(w, {x, y});
   endtask : pop
   task automatic t_dual;
      for (int i = 0; i < 4; i++)
         send_pair(10'(i * 299), ~10'(i * 299));
      for (int i = 0; i < 4; i++)
         pop(10'(i * 299), ~10'(i * 299));
   endtask : t_dual
   task automatic t_single;
      @(negedge ref_clk_i);
      single <= 1'b1;
      send_pair(10'h155, 10'h0aa);
      send_pair(10'h3c3, 10'h03c);
      send_pair(10'h001, 10'h200);
      pop(10'h155, 10'h0aa);
      pop(10'h3c3, 10'h03c);
      @(negedge ref_clk_i);
      single <= 1'b0;
   endtask : t_single
   task automatic t_fill;
      @(negedge ref_clk_i);
      ready <= 1'b0;
      for (int i = 0; i < 10; i++)
         send_pair(10'(i + 16), 10'(i + 32));
      repeat (6) @(negedge ref_clk_i);
      check(20'(cap), 20'h0);
      check(20'(ovf), 20'h1);
      ready <= 1'b1;
      for (int i = 0; i < 9; i++)
         pop(10'(i + 16), 10'(i + 32));
      repeat (10) @(negedge ref_clk_i);
      check(20'(q.size()), 20'h0);
   endtask : t_fill
   task automatic results;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   initial begin
      repeat (20) @(negedge ref_clk_i);
      reset_n_i <= 1'b1;
      t_dual();
      t_single();
      t_fill();
      results();
   end
   initial begin
      #200000;
      n_errors++;
      results();
   end
endmodule : test_tbi_receive_capture
`default_nettype wire
